// *** bench/config_watchdog_autowake_test.sv ***
// Self-checking bench for the option, watchdog and wakeup block
`timescale 1ns/100ps
`default_nettype none
module config_watchdog_autowake_test;
  import cfg_wdt_pkg::*;
  logic              mclk = 0;
  logic              rst_n = 0;
  logic              por_n = 0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 0;
  logic              avs_write = 0;
  logic [31:0]       avs_writedata = '0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              stop_instr = 0;
  logic              wakeup_rc_tick = 0;
  logic              keyboard_pending = 0;
  logic              monitor_trip = 0;
  logic              illegal_opcode, stop_mode, cpu_hold, kreq, kack, wrst;
  logic              mrst, men, mvm, pue, ife, rpe, rpo, rpoe;
  logic [3:0]        osel;
  logic [7:0]        q;
  int                errors = 0;
  int                tests_run = 0;
  int                n;

  always #10 mclk = ~mclk;

  config_watchdog_autowake dut (
    .mclk, .rst_n, .por_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest,
    .stop_instr, .ext_wake(1'b0), .wakeup_rc_tick, .keyboard_pending,
    .monitor_trip, .illegal_opcode, .stop_mode, .cpu_hold,
    .keyboard_interrupt_req(kreq), .keyboard_acknowledge(kack),
    .watchdog_reset(wrst), .monitor_reset(mrst), .monitor_enable(men),
    .monitor_voltage_mode(mvm), .irq_pin_pullup_enable(pue),
    .irq_pin_function_enable(ife), .oscillator_select(osel),
    .reset_pin_function_enable(rpe), .reset_pin_out(rpo),
    .reset_pin_oe(rpoe)
  );

  task automatic give_verdict;
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic inr(input int v, input int lo, input int hi);
    tests_run++;
    if (v < lo || v > hi) begin
      errors++;
      $display("BAD %0t count %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask

  // Bounded poll; a hang ends the run through the verdict
  task automatic waitv(ref logic s, input logic v, input int lim,
                       output int k);
    for (k = 0; k < lim && s !== v; k++) @(posedge mclk);
    if (k == lim) begin
      errors++;
      $display("BAD %0t wait ran out", $time);
      give_verdict();
    end
  endtask

  // Request held up to the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [7:0] d);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, d};
    avs_read <= !w;
    avs_write <= w;
    @(posedge mclk);
    waitv(avs_waitrequest, 1'b0, 20, n);
    q = avs_readdata[7:0];
    avs_read <= 0;
    avs_write <= 0;
    @(posedge mclk);
  endtask

  task automatic rst(input logic por);
    rst_n <= 0;
    if (por) por_n <= 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1;
    por_n <= 1;
    @(posedge mclk);
  endtask

  task automatic t_osc;
    for (int c = 0; c < 4; c++) begin
      rst(0);
      bus(1, IDX_OPTIONS_2, 8'h41 | 8'(c << 3));
      chk({4'h0, osel}, 8'(1 << c));
      chk({ife, pue, rpe}, 3'b111);
      bus(1, IDX_OPTIONS_2, 8'h80);
      bus(0, IDX_OPTIONS_2, 8'h00);
      chk(q, 8'h41 | 8'(c << 3));
    end
    bus(0, 16'h0040, 8'h00);
    chk(q, 8'h00);
    $display("done osc");
  endtask

  task automatic t_por;
    bus(1, IDX_OPTIONS_1, 8'h08);
    chk(mvm, 1'b1);
    rst(0);
    chk({mvm, rpe}, 2'b11);
    chk(rpe, 1'b1);
    rst(1);
    chk({mvm, rpe}, 2'b00);
    $display("done por");
  endtask

  task automatic t_kbd;
    stop_instr <= 1;
    @(posedge mclk);
    stop_instr <= 0;
    @(posedge mclk);
    chk({illegal_opcode, stop_mode}, 2'b10);
    bus(1, IDX_KBD_ENABLE, 8'h40);
    keyboard_pending <= 1;
    bus(0, IDX_KBD_STATUS, 8'h00);
    chk(q, 8'h08);
    chk(kreq, 1'b1);
    bus(1, IDX_KBD_STATUS, 8'h02);
    chk(kreq, 1'b0);
    keyboard_pending <= 0;
    bus(1, IDX_KBD_STATUS, 8'h06);
    chk(kack, 1'b1);
    bus(0, IDX_KBD_STATUS, 8'h00);
    chk(q, 8'h02);
    $display("done keyboard");
  endtask

  task automatic t_wake;
    rst(0);
    bus(1, IDX_OPTIONS_1, 8'h86);
    bus(1, IDX_KBD_ENABLE, 8'h40);
    for (int i = 0; i < 2; i++) begin
      stop_instr <= 1;
      @(posedge mclk);
      stop_instr <= 0;
      wakeup_rc_tick <= 1;
      waitv(stop_mode, 1'b1, 4, n);
      waitv(stop_mode, 1'b0, 700, n);
      inr(n, 510, 516);
      wakeup_rc_tick <= 0;
      waitv(cpu_hold, 1'b0, 100, n);
      inr(n, 30, 35);
      @(posedge mclk);
      bus(0, IDX_PORT_A, 8'h00);
      chk(q & 8'h40, 8'h40);
      chk(kreq, 1'b1);
      bus(1, IDX_KBD_STATUS, 8'h04);
      bus(0, IDX_PORT_A, 8'h00);
      chk(q & 8'h40, 8'h00);
    end
    $display("done wakeup");
  endtask

  task automatic t_mon;
    rst(0);
    bus(1, IDX_OPTIONS_1, 8'h86);
    chk({men, mrst}, 2'b10);
    stop_instr <= 1;
    @(posedge mclk);
    stop_instr <= 0;
    monitor_trip <= 1;
    wakeup_rc_tick <= 1;
    repeat (600) @(posedge mclk);
    chk({stop_mode, men, mrst, kreq}, 4'b1000);
    bus(0, IDX_PORT_A, 8'h00);
    chk(q, 8'h00);
    wakeup_rc_tick <= 0;
    monitor_trip <= 0;
    rst(0);
    bus(1, IDX_OPTIONS_1, 8'h46);
    stop_instr <= 1;
    @(posedge mclk);
    stop_instr <= 0;
    monitor_trip <= 1;
    @(posedge mclk);
    chk({stop_mode, men, mrst}, 3'b111);
    waitv(cpu_hold, 1'b0, 4200, n);
    inr(n, 4095, 4099);
    rst(0);
    bus(1, IDX_OPTIONS_1, 8'h20);
    chk({men, mrst}, 2'b10);
    rst(0);
    bus(1, IDX_OPTIONS_1, 8'h50);
    chk({men, mrst}, 2'b00);
    monitor_trip <= 0;
    $display("done monitor");
  endtask

  task automatic t_wdt;
    rst(0);
    bus(1, IDX_OPTIONS_2, 8'h01);
    bus(1, IDX_OPTIONS_1, 8'h80);
    repeat (4000) @(posedge mclk);
    bus(1, IDX_WDT_CLEAR, 8'h5A);
    waitv(wrst, 1'b1, 9000, n);
    inr(n, 8140, 8200);
    waitv(rpoe, 1'b1, 4, n);
    chk(rpo, 1'b0);
    waitv(rpoe, 1'b0, 60, n);
    inr(n, 31, 33);
    @(posedge mclk);
    bus(0, IDX_RESET_CAUSE, 8'h00);
    chk(q & 8'h10, 8'h10);
    rst(0);
    bus(1, IDX_OPTIONS_1, 8'h81);
    for (n = 0; n < 9000 && wrst !== 1'b1; n++) @(posedge mclk);
    inr(n, 9000, 9000);
    $display("done watchdog");
  endtask

  initial begin
    rst(1);
    bus(0, IDX_OPTIONS_1, 8'h00);
    chk(q, OPTIONS_1_RESET);
    chk({pue, osel}, 5'h11);
    t_osc();
    t_por();
    t_kbd();
    t_wake();
    t_mon();
    t_wdt();
    give_verdict();
  end
endmodule
`default_nettype wire

// *** core/cfg_wdt_pkg.sv ***
// Constants and types shared by the option, watchdog and wakeup logic
package cfg_wdt_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_PORT_A      = 16'h0000;
  localparam logic [15:0] IDX_KBD_STATUS  = 16'h001A;
  localparam logic [15:0] IDX_KBD_ENABLE  = 16'h001B;
  localparam logic [15:0] IDX_OPTIONS_2   = 16'h001E;
  localparam logic [15:0] IDX_OPTIONS_1   = 16'h001F;
  localparam logic [15:0] IDX_RESET_CAUSE = 16'h0101;
  localparam logic [15:0] IDX_WDT_CLEAR   = 16'hFFFF;
  localparam int          ADDR_W          = 18;

  // Second option register fields
  localparam int BIT_IRQ_PULLUP_DIS = 7;
  localparam int BIT_IRQ_FUNC_EN    = 6;
  localparam int BIT_OSC_OPT_HIGH   = 4;
  localparam int BIT_OSC_OPT_LOW    = 3;
  localparam int BIT_RESET_PIN_EN   = 0;

  // First option register fields
  localparam int BIT_RATE_SELECT    = 7;
  localparam int BIT_MON_STOP_EN    = 6;
  localparam int BIT_MON_RESET_DIS  = 5;
  localparam int BIT_MON_POWER_DIS  = 4;
  localparam int BIT_MON_VOLT_MODE  = 3;
  localparam int BIT_SHORT_RECOVERY = 2;
  localparam int BIT_STOP_ENABLE    = 1;
  localparam int BIT_WDT_DISABLE    = 0;

  // Keyboard, port and cause register fields
  localparam int BIT_WAKE_LATCH     = 6;
  localparam int BIT_KBD_FLAG       = 3;
  localparam int BIT_KBD_ACK        = 2;
  localparam int BIT_KBD_MASK       = 1;
  localparam int BIT_WAKE_IRQ_EN    = 6;
  localparam int BIT_CAUSE_WDT      = 4;

  // Values after reset
  localparam logic [7:0] OPTIONS_1_RESET = 8'h00;
  localparam logic [7:0] OPTIONS_2_RESET = 8'h00;

  // Cycle counts; wakeup periods in ticks
  localparam logic [12:0] RECOVERY_SHORT = 13'h0020;
  localparam logic [12:0] RECOVERY_LONG  = 13'h1000;
  localparam logic [17:0] WDT_SHORT      = 18'h0_1FF0;
  localparam logic [17:0] WDT_LONG       = 18'h3_FFF0;
  localparam logic [14:0] WAKE_SHORT     = 15'h0200;
  localparam logic [14:0] WAKE_LONG      = 15'h4000;
  localparam logic [5:0]  RESET_PIN_LOW  = 6'h20;

  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_RECOVER} power_state_t;

endpackage

// *** core/config_watchdog_autowake.sv ***
// System options, watchdog, stop recovery and wakeup request logic
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - option registers accept one write per reset
// - options decoded at indices 1E and 1F
// - reset pin select cleared by power-on only
// - monitor voltage mode cleared by power-on only
// - oscillator field: internal, external, RC, crystal
// - stop recovery 32 or 4096 cycles
// - monitor reset exit forces long recovery
// - stop disabled means illegal opcode
// - disable bit switches the watchdog off
// - watchdog timeout 2^13-16 or 2^18-16
// - wakeup period 2^9 or 2^14 ticks
// - monitor reset and power disables
// - monitor trip mode 5V or 3V
// - irq pullup disable and function enable
// - reset pin function from select bit
// - six-bit counter after twelve-bit prescaler
// - clear-address write clears counter, stages 12-5
// - timeout pulls pin 32 cycles when reset pin select set, always sets cause
// - wakeup latch is read-only pending bit
// - keyboard flag pending, upper bits zero
// - acknowledge clears requests, reads zero
// - mask blocks keyboard and wakeup interrupts
// - wakeup latched only when enabled
// - wakeup latch sits at port bit 6
// - wakeup counter restarts on stop entry
// - stop entry clears the prescaler
module config_watchdog_autowake
  import cfg_wdt_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic                          por_n,
  input  wire logic [cfg_wdt_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic [31:0]                        avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          stop_instr,
  input  wire logic                          ext_wake,
  input  wire logic                          wakeup_rc_tick,
  input  wire logic                          keyboard_pending,
  input  wire logic                          monitor_trip,
  output logic                               illegal_opcode,
  output logic                               stop_mode,
  output logic                               cpu_hold,
  output logic                               keyboard_interrupt_req,
  output logic                               keyboard_acknowledge,
  output logic                               watchdog_reset,
  output logic                               monitor_reset,
  output logic                               monitor_enable,
  output logic                               monitor_voltage_mode,
  output logic                               irq_pin_pullup_enable,
  output logic                               irq_pin_function_enable,
  output logic [3:0]                         oscillator_select,
  output logic                               reset_pin_function_enable,
  output logic                               reset_pin_out,
  output logic                               reset_pin_oe
);
  import cfg_wdt_pkg::*;

  logic         done_q;
  logic         take_rd;
  logic         take_wr;
  logic [15:0]  idx;
  logic [7:0]   wdata;
  logic         opt1_written_q;
  logic         opt2_written_q;
  logic [7:0]   opt1_q;
  logic [7:0]   opt2_q;
  logic         volt_mode_q;
  logic         reset_pin_en_q;
  logic         wr_opt1;
  logic         wr_opt2;
  logic         kbd_mask_q;
  logic         wake_irq_en_q;
  logic         wake_latch_q;
  logic         ack_wr;
  logic         kbd_flag;
  logic         cause_wdt_q;
  logic [5:0]   pin_cnt_q;
  logic         illegal_q;
  logic         ack_q;
  power_state_t state_q;
  logic [12:0]  recover_cnt_q;
  logic         stop_entry;
  logic         wake_event;
  logic         wdt_timeout;
  logic         wake_done;
  logic         monitor_reset_req;
  logic [31:0]  rdata_d;

  // Bus slave: one wait cycle, then the answer
  assign avs_waitrequest = (avs_read | avs_write) & ~done_q;
  assign take_rd = avs_read & ~avs_waitrequest;
  assign take_wr = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign idx     = avs_address[ADDR_W-1:2];
  assign wdata   = avs_writedata[7:0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (avs_read | avs_write) & ~done_q;
    end
  end

  assign wr_opt1 = take_wr & (idx == IDX_OPTIONS_1) & ~opt1_written_q;
  assign wr_opt2 = take_wr & (idx == IDX_OPTIONS_2) & ~opt2_written_q;
  assign ack_wr  = take_wr & (idx == IDX_KBD_STATUS) & wdata[BIT_KBD_ACK];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opt1_written_q <= 1'b0;
      opt2_written_q <= 1'b0;
    end else begin
      if (wr_opt1) begin
        opt1_written_q <= 1'b1;
      end
      if (wr_opt2) begin
        opt2_written_q <= 1'b1;
      end
    end
  end

  // Bits cleared by any reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opt1_q <= OPTIONS_1_RESET;
      opt2_q <= OPTIONS_2_RESET;
    end else begin
      if (wr_opt1) begin
        opt1_q <= wdata;
      end
      if (wr_opt2) begin
        opt2_q <= wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      volt_mode_q    <= 1'b0;
      reset_pin_en_q <= 1'b0;
    end else begin
      if (wr_opt1) begin
        volt_mode_q <= wdata[BIT_MON_VOLT_MODE];
      end
      if (wr_opt2) begin
        reset_pin_en_q <= wdata[BIT_RESET_PIN_EN];
      end
    end
  end

  assign irq_pin_pullup_enable   = ~opt2_q[BIT_IRQ_PULLUP_DIS];
  assign irq_pin_function_enable = opt2_q[BIT_IRQ_FUNC_EN];
  assign oscillator_select = 4'h1 << {opt2_q[BIT_OSC_OPT_HIGH],
                                      opt2_q[BIT_OSC_OPT_LOW]};
  assign reset_pin_function_enable = reset_pin_en_q;

  // monitor kept in stop only if powered and its stop enable bit is set
  assign monitor_enable = ~opt1_q[BIT_MON_POWER_DIS] &
                          (state_q != ST_STOP | opt1_q[BIT_MON_STOP_EN]);
  assign monitor_reset_req = monitor_trip & monitor_enable &
                             ~opt1_q[BIT_MON_RESET_DIS];
  assign monitor_reset = monitor_reset_req;
  assign monitor_voltage_mode = volt_mode_q;

  // Stop control
  assign stop_entry = (state_q == ST_RUN) & stop_instr &
                      opt1_q[BIT_STOP_ENABLE];
  assign wake_event = keyboard_interrupt_req | ext_wake;
  assign stop_mode  = (state_q == ST_STOP);
  assign cpu_hold   = (state_q != ST_RUN);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= ST_RUN;
      recover_cnt_q <= 13'h0000;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          if (stop_entry) begin
            state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (monitor_reset_req) begin
            state_q       <= ST_RECOVER;
            recover_cnt_q <= RECOVERY_LONG - 13'h0001;
          end else if (wake_event) begin
            state_q       <= ST_RECOVER;
            recover_cnt_q <= opt1_q[BIT_SHORT_RECOVERY] ?
                             RECOVERY_SHORT - 13'h0001 :
                             RECOVERY_LONG - 13'h0001;
          end
        end
        ST_RECOVER: begin
          if (recover_cnt_q == 13'h0000) begin
            state_q <= ST_RUN;
          end else begin
            recover_cnt_q <= recover_cnt_q - 13'h0001;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= (state_q == ST_RUN) & stop_instr &
                   ~opt1_q[BIT_STOP_ENABLE];
    end
  end
  assign illegal_opcode = illegal_q;

  wdt_chain u_wdt (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .run_en      (state_q == ST_RUN),
    .wdt_disable (opt1_q[BIT_WDT_DISABLE]),
    .rate_short  (opt1_q[BIT_RATE_SELECT]),
    .service     (take_wr & (idx == IDX_WDT_CLEAR)),
    .stop_clear  (stop_entry),
    .timeout     (wdt_timeout)
  );
  assign watchdog_reset = wdt_timeout;

  wake_timer u_wake (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .active      (state_q == ST_STOP),
    .restart     (stop_entry),
    .tick        (wakeup_rc_tick),
    .rate_short  (opt1_q[BIT_RATE_SELECT]),
    .period_done (wake_done)
  );

  // pin low and cause flag; kept over internal reset
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      pin_cnt_q   <= 6'h00;
      cause_wdt_q <= 1'b0;
    end else begin
      if (wdt_timeout && reset_pin_en_q) begin
        pin_cnt_q <= RESET_PIN_LOW;
      end else if (pin_cnt_q != 6'h00) begin
        pin_cnt_q <= pin_cnt_q - 6'h01;
      end
      if (wdt_timeout) begin
        cause_wdt_q <= 1'b1;
      end else if (take_rd && idx == IDX_RESET_CAUSE) begin
        cause_wdt_q <= 1'b0;
      end
    end
  end
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe  = (pin_cnt_q != 6'h00);

  // acknowledge clears; a new request wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_latch_q <= 1'b0;
    end else if (wake_done && wake_irq_en_q) begin
      wake_latch_q <= 1'b1;
    end else if (ack_wr) begin
      wake_latch_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      kbd_mask_q    <= 1'b0;
      wake_irq_en_q <= 1'b0;
      ack_q         <= 1'b0;
    end else begin
      ack_q <= ack_wr;
      if (take_wr && idx == IDX_KBD_STATUS) begin
        kbd_mask_q <= wdata[BIT_KBD_MASK];
      end
      if (take_wr && idx == IDX_KBD_ENABLE) begin
        wake_irq_en_q <= wdata[BIT_WAKE_IRQ_EN];
      end
    end
  end
  // Keyboard side clears its own request on this pulse
  assign keyboard_acknowledge = ack_q;

  assign kbd_flag = wake_latch_q | keyboard_pending;
  assign keyboard_interrupt_req = kbd_flag & ~kbd_mask_q;

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (idx)
      IDX_PORT_A:      rdata_d[BIT_WAKE_LATCH] = wake_latch_q;
      IDX_KBD_STATUS: begin
        rdata_d[BIT_KBD_FLAG] = kbd_flag;
        rdata_d[BIT_KBD_MASK] = kbd_mask_q;
      end
      IDX_KBD_ENABLE:  rdata_d[BIT_WAKE_IRQ_EN] = wake_irq_en_q;
      IDX_OPTIONS_1: begin
        rdata_d[7:0] = opt1_q;
        rdata_d[BIT_MON_VOLT_MODE] = volt_mode_q;
      end
      IDX_OPTIONS_2: begin
        rdata_d[7:0] = opt2_q;
        rdata_d[BIT_RESET_PIN_EN] = reset_pin_en_q;
      end
      IDX_RESET_CAUSE: rdata_d[BIT_CAUSE_WDT] = cause_wdt_q;
      default:         rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !done_q) begin
      avs_readdata <= rdata_d;
    end
  end

  sequence s_short_recover;
    (state_q == ST_RECOVER) [*8] ##24 (state_q == ST_RECOVER)
      ##1 (state_q == ST_RUN);
  endsequence

  property p_once;
    @(posedge mclk) disable iff (!rst_n)
    take_wr && idx == IDX_OPTIONS_1 && opt1_written_q
      |=> opt1_q == $past(opt1_q);
  endproperty
  a_once: assert property (p_once)
    else $error("second option write took effect");

  property p_short;
    @(posedge mclk) disable iff (!rst_n)
    state_q == ST_STOP && wake_event && !monitor_reset_req &&
      opt1_q[BIT_SHORT_RECOVERY] |=> s_short_recover;
  endproperty
  a_short: assert property (p_short)
    else $error("short recovery not 32 cycles");

  property p_long_monitor;
    @(posedge mclk) disable iff (!rst_n)
    state_q == ST_STOP && monitor_reset_req
      |=> recover_cnt_q == RECOVERY_LONG - 13'h0001;
  endproperty
  a_long_monitor: assert property (p_long_monitor)
    else $error("monitor exit did not use long recovery");

  property p_illegal;
    @(posedge mclk) disable iff (!rst_n)
    state_q == ST_RUN && stop_instr && !opt1_q[BIT_STOP_ENABLE]
      |=> illegal_opcode && state_q == ST_RUN;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("disabled stop not trapped");

  property p_ack;
    @(posedge mclk) disable iff (!rst_n)
    ack_wr && !(wake_done && wake_irq_en_q)
      |=> !wake_latch_q ##0 keyboard_acknowledge;
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge did not clear latch");

  property p_mask;
    @(posedge mclk) disable iff (!rst_n)
    kbd_mask_q |-> !keyboard_interrupt_req;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked request reached interrupt");

  property p_no_enable;
    @(posedge mclk) disable iff (!rst_n)
    wake_done && !wake_irq_en_q && !wake_latch_q |=> !wake_latch_q;
  endproperty
  a_no_enable: assert property (p_no_enable)
    else $error("wakeup latched while disabled");

  property p_pin_pulse;
    @(posedge mclk) disable iff (!por_n)
    wdt_timeout && reset_pin_en_q
      |=> reset_pin_oe ##31 reset_pin_oe ##1 !reset_pin_oe;
  endproperty
  a_pin_pulse: assert property (p_pin_pulse)
    else $error("reset pin pulse not 32 cycles");

  property p_cause;
    @(posedge mclk) disable iff (!por_n)
    wdt_timeout |=> cause_wdt_q;
  endproperty
  a_cause: assert property (p_cause)
    else $error("watchdog cause flag not set");
endmodule
`default_nettype wire

// *** core/wake_timer.sv ***
// Wakeup period counter, active only in stop
`timescale 1ns/100ps
`default_nettype none
module wake_timer
  import cfg_wdt_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic active,
  input  wire logic restart,
  input  wire logic tick,
  input  wire logic rate_short,
  output logic      period_done
);
  logic [14:0] cnt_q;
  logic [14:0] period;

  assign period = rate_short ? WAKE_SHORT : WAKE_LONG;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q       <= 15'h0000;
      period_done <= 1'b0;
    end else if (restart) begin
      cnt_q       <= 15'h0000;
      period_done <= 1'b0;
    end else begin
      period_done <= 1'b0;
      if (active && tick) begin
        if (cnt_q == period - 15'h0001) begin
          cnt_q       <= 15'h0000;
          period_done <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 15'h0001;
        end
      end
    end
  end

  property p_restart_zero;
    @(posedge mclk) disable iff (!rst_n)
    restart |=> cnt_q == 15'h0000 && !period_done;
  endproperty
  a_restart_zero: assert property (p_restart_zero)
    else $error("wakeup counter not restarted");
endmodule
`default_nettype wire

// *** core/wdt_chain.sv ***
// Watchdog prescaler and counter chain
`timescale 1ns/100ps
`default_nettype none
module wdt_chain
  import cfg_wdt_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic run_en,
  input  wire logic wdt_disable,
  input  wire logic rate_short,
  input  wire logic service,
  input  wire logic stop_clear,
  output logic      timeout
);
  logic [11:0] pre_q;
  logic [5:0]  wdt_q;
  logic [17:0] limit;
  logic        hit;

  assign limit = rate_short ? WDT_SHORT : WDT_LONG;
  assign hit = run_en & ~wdt_disable &
               ({wdt_q, pre_q} == limit - 18'h0_0001);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 12'h000;
    end else if (stop_clear || hit) begin
      pre_q <= 12'h000;
    end else if (service) begin
      pre_q <= {8'h00, pre_q[3:0]};
    end else if (run_en) begin
      pre_q <= pre_q + 12'h001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_q <= 6'h00;
    end else if (wdt_disable || service || hit) begin
      wdt_q <= 6'h00;
    end else if (run_en && pre_q == 12'hFFF) begin
      wdt_q <= wdt_q + 6'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timeout <= 1'b0;
    end else begin
      timeout <= hit;
    end
  end

  property p_service_clears;
    @(posedge mclk) disable iff (!rst_n)
    service && !stop_clear |=> wdt_q == 6'h00 && pre_q[11:4] == 8'h00;
  endproperty
  a_service_clears: assert property (p_service_clears)
    else $error("service write did not clear the chain");

  property p_disabled_quiet;
    @(posedge mclk) disable iff (!rst_n)
    wdt_disable |=> wdt_q == 6'h00 && !timeout;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled watchdog counted or fired");
endmodule
`default_nettype wire
